// >>> design/rbm_pkg.sv
// package for the reset and boot-strap capture block
//
// What this block does
// R1 - reset pin low holds all logic in reset, acting as direct hardware reset
// R2 - on reset pin release, boot-select strap level is captured as boot mode
// R3 - internal reset drops synchronously after a fixed count of clock cycles
// R4 - reset-status output pin follows the internal reset state continuously
// R5 - board asserts reset with TRST for full reset; reset alone keeps debug (no TRST or debug logic here; reset pin resets everything)
// R6 - power-on reset asserts at power-up and merges into internal reset
// R7 - high boot-select boots externally only when flash is not secured
// R8 - high wide-address strap gives 20 address lines; low keeps narrow bus
// R9 - wide-address effect is qualified by boot-select and flash security
// R10 - writing one to reset-pin pull-up disable bit turns that pull-up off
// R11 - software sets boot-select pull-up disable when that strap is tied low
// R12 - software sets wide-address pull-up disable when that strap is tied low
// R13 - boot-select high with flash secured falls back to internal, 16 lines
// R14 - all pull-up disable bits reset to zero, pull-ups on during reset
package rbm_pkg;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] RBM_PULLUP_OFS = 12'h000;
  localparam logic [11:0] RBM_STATUS_OFS = 12'h004;
  // ----------------------------------------
  // field positions, pull-up reset value and address widths
  // ----------------------------------------
  localparam int RBM_PU_RESET_BIT = 0;
  localparam int RBM_PU_BOOT_BIT = 1;
  localparam int RBM_PU_WIDE_BIT = 2;
  localparam int RBM_ST_BOOT_SELECT_STRAP_BIT = 0;
  localparam int RBM_ST_SECURED_BIT = 1;
  localparam int RBM_ST_WIDE_BIT = 2;
  localparam int RBM_ST_RELEASED_BIT = 3;
  localparam logic [2:0] RBM_PULLUP_RST = 3'h0;
  localparam int RBM_ADDR_NARROW = 16;
  localparam int RBM_ADDR_WIDE = 20;
  // ----------------------------------------
  // release delay
  // ----------------------------------------
  localparam int RBM_RELEASE_CYCLES = 32;
endpackage

// >>> design/rbm_reset_boot.sv
// reset release, boot-strap capture and pull-up control with an apb slave
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rbm_reset_boot
  import rbm_pkg::*;
#(
  parameter int RELEASE_CYCLES = rbm_pkg::RBM_RELEASE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic por_n,
  input wire logic boot_select_strap,
  input wire logic wide_address_strap,
  input wire logic flash_secured,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic reset_status_out,
  output logic int_rst_n,
  output logic boot_external,
  output logic [4:0] addr_lines,
  output logic [2:0] pullup_disable_reg
);
  import rbm_pkg::*;

  // the release counter is 16 bits wide and must reach at least one cycle
  if (RELEASE_CYCLES < 1 || RELEASE_CYCLES > 65535) begin : g_bad_release
    $error("RELEASE_CYCLES out of range");
  end

  // ----------------------------------------
  // reset combining and release counter
  // ----------------------------------------
  logic arst_n;
  logic [15:0] cnt_q, cnt_d;
  logic rel_q, rel_d;
  logic cap_q, cap_d;
  logic boot_q, boot_d;
  logic wide_q, wide_d;
  logic sec_q, sec_d;

  // both sources reset everything asynchronously
  assign arst_n = presetn & por_n; // R1 R6

  always_comb begin
    cnt_d = cnt_q;
    rel_d = rel_q;
    cap_d = 1'b0;
    boot_d = boot_q;
    wide_d = wide_q;
    sec_d = sec_q;
    if (!cap_q && !rel_q) begin
      // straps caught on the first edge after release, never under reset
      cap_d = 1'b1;
      sec_d = flash_secured;
      boot_d = boot_select_strap & ~flash_secured; // R2 R7 R13
      wide_d = wide_address_strap & boot_select_strap & ~flash_secured; // R8 R9
    end
    if (!rel_q) begin
      if (cnt_q == 16'(RELEASE_CYCLES - 1)) begin
        rel_d = 1'b1; // R3
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 16'h0000;
      rel_q <= 1'b0;
      cap_q <= 1'b0;
      boot_q <= 1'b0;
      wide_q <= 1'b0;
      sec_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      rel_q <= rel_d;
      cap_q <= cap_d | cap_q;
      boot_q <= boot_d;
      wide_q <= wide_d;
      sec_q <= sec_d;
    end
  end

  // ----------------------------------------
  // outputs from flip-flops
  // ----------------------------------------
  logic reset_status_out_d;
  logic [4:0] lines_d;
  always_comb begin
    reset_status_out_d = ~rel_d; // R4
    lines_d = wide_d ? 5'(RBM_ADDR_WIDE) : 5'(RBM_ADDR_NARROW); // R8 R13
  end

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      reset_status_out <= 1'b1; // R4
      int_rst_n <= 1'b0; // R1
      boot_external <= 1'b0;
      addr_lines <= 5'h10;
    end else begin
      reset_status_out <= reset_status_out_d;
      int_rst_n <= rel_d;
      boot_external <= boot_d;
      addr_lines <= lines_d;
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  logic [2:0] pu_d;
  logic [31:0] rd_d;
  logic rdy_d, err_d, hit;
  always_comb begin
    pu_d = pullup_disable_reg;
    rd_d = prdata;
    rdy_d = 1'b0;
    err_d = 1'b0;
    hit = (paddr == RBM_PULLUP_OFS) || (paddr == RBM_STATUS_OFS);
    if (psel && penable && !pready) begin
      rdy_d = 1'b1;
      err_d = ~hit;
      rd_d = 32'h0000_0000;
      if (pwrite && paddr == RBM_PULLUP_OFS) begin
        pu_d = pwdata[2:0]; // R10
      end
      if (!pwrite && paddr == RBM_PULLUP_OFS) begin
        rd_d[2:0] = pullup_disable_reg;
      end
      if (!pwrite && paddr == RBM_STATUS_OFS) begin
        rd_d[RBM_ST_BOOT_SELECT_STRAP_BIT] = boot_q;
        rd_d[RBM_ST_SECURED_BIT] = sec_q;
        rd_d[RBM_ST_WIDE_BIT] = wide_q;
        rd_d[RBM_ST_RELEASED_BIT] = rel_q;
      end
    end
  end

  always_ff @(posedge pclk or negedge arst_n) begin
    if (!arst_n) begin
      pullup_disable_reg <= RBM_PULLUP_RST; // R14
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pullup_disable_reg <= pu_d;
      prdata <= rd_d;
      pready <= rdy_d;
      pslverr <= err_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RESET_STATUS_OUT_FOLLOWS: assert property (@(posedge pclk) disable iff (!arst_n)
    reset_status_out == ~int_rst_n) else $error("status pin differs from reset"); // R4
  AST_RELEASE_TIME: assert property (@(posedge pclk) disable iff (!arst_n)
    $rose(int_rst_n) |-> cnt_q == 16'(RELEASE_CYCLES - 1)) else $error("early release"); // R3
  AST_NO_EXT_SECURED: assert property (@(posedge pclk) disable iff (!arst_n)
    sec_q |-> !boot_q && !wide_q) else $error("secured boot went external"); // R13
  AST_WIDE_LINES: assert property (@(posedge pclk) disable iff (!arst_n)
    cap_q |-> ##1 (addr_lines == (wide_q ? 5'h14 : 5'h10))) else $error("bad lines"); // R8
  AST_WIDE_QUAL: assert property (@(posedge pclk) disable iff (!arst_n)
    wide_q |-> boot_q) else $error("wide without external boot"); // R9
  AST_PU_WRITE: assert property (@(posedge pclk) disable iff (!arst_n)
    psel && penable && pwrite && !pready && paddr == RBM_PULLUP_OFS
    |=> pullup_disable_reg == $past(pwdata[2:0])) else $error("pull-up write lost"); // R10
  // int_rst_n and rel_q load the same next value, so they agree in every cycle
  AST_HELD_RESET: assert property (@(posedge pclk) disable iff (!arst_n)
    !rel_q |-> !int_rst_n) else $error("reset left early"); // R1
  AST_BOOT_CAPTURE: assert property (@(posedge pclk) disable iff (!arst_n)
    !cap_q && !rel_q |=> boot_q == $past(boot_select_strap && !flash_secured))
    else $error("boot strap not caught"); // R2
  COV_EXT_BOOT: cover property (@(posedge pclk) $rose(boot_external));
  COV_WIDE: cover property (@(posedge pclk) addr_lines == 5'h14);
  COV_RELEASE: cover property (@(posedge pclk) $rose(int_rst_n));

  // ----------------------------------------
  // bus, capture, status-pin and counter checks
  // ----------------------------------------
  // the answer is a single-cycle pulse; a held pready would take a second transfer
  AST_READY_PULSE: assert property (@(posedge pclk) disable iff (!arst_n)
    pready |=> !pready) else $error("pready held too long");
  // one wait state: the access phase always ends on the following edge
  AST_ANSWER_TIME: assert property (@(posedge pclk) disable iff (!arst_n)
    psel && penable && !pready |=> pready) else $error("answer late");
  AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!arst_n)
    pslverr |-> pready) else $error("error without ready");
  // a write to an unmapped offset must leave the pull-up bits alone
  AST_UNMAPPED_WRITE: assert property (@(posedge pclk) disable iff (!arst_n)
    psel && penable && pwrite && !pready && !hit
    |=> $stable(pullup_disable_reg)) else $error("unmapped write landed"); // R10
  // straps are looked at once; later pin changes must not move the mode
  AST_BOOT_STABLE: assert property (@(posedge pclk) disable iff (!arst_n)
    cap_q |=> $stable(boot_external)) else $error("boot mode moved"); // R2
  AST_EXT_UNSECURED: assert property (@(posedge pclk) disable iff (!arst_n)
    boot_external |-> !sec_q) else $error("external boot on secured flash"); // R7
  AST_STATUS_IN_RESET: assert property (@(posedge pclk) disable iff (!arst_n)
    !int_rst_n |-> reset_status_out) else $error("status pin low in reset"); // R4
  AST_CNT_BOUND: assert property (@(posedge pclk) disable iff (!arst_n)
    int'(cnt_q) < RELEASE_CYCLES) else $error("release counter overran"); // R3
  COV_PU_WRITE: cover property (@(posedge pclk) pready && !pslverr && |pullup_disable_reg);
  COV_UNMAPPED: cover property (@(posedge pclk) pready && pslverr);
endmodule
`default_nettype wire

// >>> verif/rbm_board.sv
// board model: reset button and strap resistors
`timescale 1ns/1ns
`default_nettype none
module rbm_board (
  input wire logic pclk,
  input wire logic [2:0] cfg,
  input wire logic hold,
  output logic presetn,
  output logic boot_select_strap,
  output logic wide_address_strap,
  output logic flash_secured
);
  // reset pin only; trst stays idle so debug logic would survive
  always_ff @(posedge pclk) begin
    presetn <= !hold;
    {flash_secured, boot_select_strap, wide_address_strap} <= cfg;
  end
endmodule
`default_nettype wire

// >>> verif/rbm_reset_boot_test.sv
// self-checking bench for the reset and boot-strap block
`timescale 1ns/1ns
`default_nettype none
module rbm_reset_boot_test;
  import rbm_pkg::*;
  localparam int RC = 4;
  logic pclk, por_n, hold, psel, penable, pwrite, presetn, bs, ws, fs, err;
  logic pready, pslverr, reset_status_out, int_rst_n, boot_external;
  logic [2:0] cfg, pullup_disable_reg;
  logic [4:0] addr_lines;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int failures = 0;
  int num_checks = 0;
  rbm_board i_rbm_board (.pclk(pclk), .cfg(cfg), .hold(hold), .presetn(presetn),
    .boot_select_strap(bs), .wide_address_strap(ws), .flash_secured(fs));
  rbm_reset_boot #(.RELEASE_CYCLES(RC)) i_rbm_reset_boot (.pclk(pclk), .presetn(presetn),
    .por_n(por_n), .boot_select_strap(bs), .wide_address_strap(ws), .flash_secured(fs),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_status_out(reset_status_out),
    .int_rst_n(int_rst_n), .boot_external(boot_external), .addr_lines(addr_lines),
    .pullup_disable_reg(pullup_disable_reg));
  task automatic close_out;
    if (failures == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // entered right after a rising edge; returns one edge after the edge that sampled pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) failures++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_boot(input logic [2:0] c);
    int n;
    logic ext;
    @(posedge pclk);
    cfg <= c;
    hold <= 1'b1;
    repeat (3) @(posedge pclk);
    #1;
    chk({reset_status_out, int_rst_n, boot_external, addr_lines}, {3'b100, 5'h10});
    @(posedge pclk);
    hold <= 1'b0;
    @(posedge presetn);
    n = 0;
    while (int_rst_n !== 1'b1 && n < 50) begin
      @(posedge pclk);
      #1;
      n++;
      chk(reset_status_out ^ int_rst_n, 1'b1);
    end
    chk(n, RC);
    ext = c[1] & !c[2];
    chk(boot_external, ext);
    chk(addr_lines, (ext & c[0]) ? 5'h14 : 5'h10);
  endtask
  task automatic t_regs;
    @(posedge pclk);
    apb(1'b0, RBM_PULLUP_OFS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, RBM_PULLUP_OFS, {29'h0, ~cfg[0], ~cfg[1], 1'b0});
    apb(1'b0, RBM_PULLUP_OFS, 32'h0);
    chk(rd, {29'h0, ~cfg[0], ~cfg[1], 1'b0});
    apb(1'b1, RBM_PULLUP_OFS, 32'hFFFF_FFFF);
    apb(1'b0, RBM_PULLUP_OFS, 32'h0);
    chk(rd, 32'h7);
    chk(pullup_disable_reg, 3'h7);
    apb(1'b0, RBM_STATUS_OFS, 32'h0);
    chk(rd, 32'hD);
    apb(1'b0, 12'h008, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
  endtask
  task automatic t_por;
    por_n <= 1'b0;
    repeat (2) @(posedge pclk);
    #1;
    chk({int_rst_n, pullup_disable_reg}, 4'h0);
    @(posedge pclk);
    por_n <= 1'b1;
    repeat (RC + 3) @(posedge pclk);
    #1;
    chk(int_rst_n, 1'b1);
  endtask
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    close_out;
  end
  initial begin
    {por_n, hold, cfg, psel, penable, pwrite, paddr, pwdata} = {2'b01, 50'h0};
    repeat (5) @(posedge pclk);
    por_n <= 1'b1;
    for (int i = 0; i < 8; i++) t_boot(i[2:0]);
    t_boot(3'b011);
    t_regs;
    t_por;
    close_out;
  end
endmodule
`default_nettype wire
